// File: ptb_pkg.sv
// constants, types and helpers shared by the periodic timebase design
package ptb_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h08;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0C;
  // control field positions
  localparam int BIT_FLAG = 7;
  localparam int SEL_LSB = 4;
  localparam int BIT_ACK = 3;
  localparam int BIT_IRQ_EN = 2;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_EVENT = 0;
  // values after reset
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic [2:0] RST_SELECT = 3'h0;
  localparam logic [14:0] RST_COUNT = 15'h0000;
  localparam logic [2:0] RST_SYNC = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // ------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------
  localparam int STAGES = 15;
  // apb answer states
  typedef enum logic [0:0] {APB_IDLE, APB_ANSWER} ptb_apb_state_type;
  // counter bit whose rise marks the selected tap (half period, then full)
  function automatic logic [3:0] tapBit(input logic [2:0] sel);
    unique case (sel)
      3'h0: tapBit = 4'hE; // 32768
      3'h1: tapBit = 4'hC; // 8192
      3'h2: tapBit = 4'hA; // 2048
      3'h3: tapBit = 4'h6; // 128
      3'h4: tapBit = 4'h5; // 64
      3'h5: tapBit = 4'h4; // 32
      3'h6: tapBit = 4'h3; // 16
      3'h7: tapBit = 4'h2; // 8
    endcase
  endfunction
endpackage

// File: ptb_reg_if.sv
// register access carrier between bus slave and timebase core
`timescale 1ns/1ps
`default_nettype none
interface ptb_reg_if;
  logic wrEn;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic known;
  // bus side
  modport bus (output wrEn, output addr, output wdata, input rdata, input known);
  // register side
  modport regs (input wrEn, input addr, input wdata, output rdata, output known);
endinterface
`default_nettype wire

// File: ptb_apb_slave.sv
// apb slave with one wait state, drives the register carrier
`timescale 1ns/1ps
`default_nettype none
module ptb_apb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // registers
  ptb_reg_if.bus regs
);
  typedef struct packed {
    ptb_pkg::ptb_apb_state_type state;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } ptb_apb_type;
  ptb_apb_type s;
  ptb_apb_type next_s;

  // write commits at the edge where pready is seen high
  assign regs.wrEn = (s.state == ptb_pkg::APB_ANSWER) && psel && penable && pwrite && !s.err;
  assign regs.addr = paddr;
  assign regs.wdata = pwdata;
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.err;

  // answer one cycle into the access phase
  always_comb begin
    next_s = s;
    unique case (s.state)
      ptb_pkg::APB_IDLE: begin
        if (psel && penable) begin
          next_s.state = ptb_pkg::APB_ANSWER;
          next_s.ready = 1'b1;
          next_s.err = !regs.known;
          next_s.rdata = (!pwrite && regs.known) ? regs.rdata : ptb_pkg::READ_ZERO;
        end
      end
      ptb_pkg::APB_ANSWER: begin
        next_s.state = ptb_pkg::APB_IDLE;
        next_s.ready = 1'b0;
        next_s.err = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{ptb_pkg::APB_IDLE, 1'b0, 1'b0, ptb_pkg::READ_ZERO};
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// File: ptb_divider.sv
// fifteen stage divider chain with tap rise detector
`timescale 1ns/1ps
`default_nettype none
module ptb_divider (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] dividerSelect,
  // results
  output logic fire,
  output logic [14:0] count
);
  typedef struct packed {
    logic [14:0] count;
    logic fire;
  } ptb_div_type;
  ptb_div_type s;
  ptb_div_type next_s;
  logic [14:0] bumped;
  logic [3:0] tap;

  assign fire = s.fire;
  assign count = s.count;
  assign tap = ptb_pkg::tapBit(dividerSelect);
  assign bumped = s.count + 15'h0001;

  // [RULE3] held at zero
  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    if (clear) begin
      next_s.count = ptb_pkg::RST_COUNT;
    end else if (run && tick) begin
      next_s.count = bumped;
      // [RULE4] rollover at tap
      next_s.fire = bumped[tap] && !s.count[tap];
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{ptb_pkg::RST_COUNT, 1'b0};
    end else begin
      s <= next_s;
    end
  end

  property p_clear_zero;
    @(posedge clk) disable iff (!rstn) clear |=> (count == 15'h0000) && !fire;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("divider not held at zero"); // [RULE3]

  property p_fire_phase;
    @(posedge clk) disable iff (!rstn)
      fire |-> ((int'(count) % (2 << tap)) == (1 << tap));
  endproperty
  a_fire_phase: assert property (p_fire_phase) else $error("event off the tap phase"); // [RULE6]

  property p_fire_cause;
    @(posedge clk) disable iff (!rstn) fire |-> $past(run && tick && !clear);
  endproperty
  a_fire_cause: assert property (p_fire_cause) else $error("event without a counted tick"); // [RULE8]
endmodule
`default_nettype wire

// File: ptb_timebase.sv
// periodic timebase interrupt generator, top with apb registers
// Notes on behaviour
// [RULE1] The timebase is a fifteen stage binary divider of which eight outputs can serve as the tap.
// [RULE2] The divider counts the external clock when its enable is set, otherwise the internal clock.
// [RULE3] The counter sits at zero while the timebase is off and counts once it is turned on.
// [RULE4] Each rollover at the selected tap sets the timebase flag.
// [RULE5] A set flag with the interrupt enable on raises the interrupt request.
// [RULE6] The first flag comes after half the chosen period and every later one after a full period.
// [RULE7] Select codes 0 to 7 pick dividers 32768, 8192, 2048, 128, 64, 32, 16 and 8.
// [RULE8] The event period is the chosen divider over the timebase clock rate.
// [RULE9] Writing one to the acknowledge bit clears the flag, zero does nothing, and it reads zero.
// [RULE10] The flag is read only and ignores writes to its bit.
// [RULE11] Reset clears the timebase enable and the interrupt enable.
// [RULE12] Software leaves the divider select alone while the timebase is on.
// [RULE13] In wait mode the timebase keeps counting and interrupting.
// [RULE14] In stop mode it keeps running only when the oscillator is kept on in stop.
// [RULE15] Without that setting the timebase halts during stop.
// [RULE16] Software should turn the timebase off before wait or stop when it is not needed.
// [RULE17] The request is a level held while flag and enable are both set and drops on acknowledge.
`timescale 1ns/1ps
`default_nettype none
module ptb_timebase (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb register bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timebase clock sources, asynchronous pins
  input wire logic externalClock,
  input wire logic internalClock,
  // clock generator settings
  input wire logic externalClockEnable,
  input wire logic oscillatorRunInStop,
  // power modes
  input wire logic waitMode,
  input wire logic stopMode,
  // interrupt
  output logic timebaseIrq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] extSync;
    logic [2:0] intSync;
    logic extLevel;
    logic intLevel;
    logic enable;
    logic irqEnable;
    logic [2:0] dividerSelect;
    logic flag;
    logic irq;
  } ptb_core_type;
  ptb_core_type s;
  ptb_core_type next_s;

  ptb_reg_if regs ();

  logic extRise;
  logic intRise;
  logic tick;
  logic run;
  logic fire;
  logic [14:0] count;
  logic ackWrite;
  logic clearWrite;
  logic [7:0] controlRead;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  ptb_apb_slave u_apb (
    .clk(clk),
    .rstn(rstn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .regs(regs.bus)
  );

  // ------------------------------------------------------------
  // clock source edges
  // ------------------------------------------------------------
  // edge counts once stages two and three agree on a new level
  assign extRise = (s.extSync[2] == s.extSync[1]) && s.extSync[1] && !s.extLevel;
  assign intRise = (s.intSync[2] == s.intSync[1]) && s.intSync[1] && !s.intLevel;
  // [RULE2] source follows external enable
  assign tick = externalClockEnable ? extRise : intRise;
  // [RULE13] wait mode does not gate the chain
  // [RULE14] [RULE15] stop halts unless oscillator kept on
  assign run = s.enable && !(stopMode && !oscillatorRunInStop);

  // ------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------
  // [RULE1] fifteen stages, eight taps
  ptb_divider u_div (
    .clk(clk),
    .rstn(rstn),
    .tick(tick),
    .run(run),
    .clear(!s.enable),
    .dividerSelect(s.dividerSelect),
    .fire(fire),
    .count(count)
  );

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  // [RULE9] acknowledge reads as zero
  assign controlRead = {s.flag, s.dividerSelect, 1'b0, s.irqEnable, s.enable, 1'b0};
  assign ackWrite = regs.wrEn && (regs.addr == ptb_pkg::OFF_CONTROL) && regs.wdata[ptb_pkg::BIT_ACK];
  assign clearWrite = regs.wrEn && (regs.addr == ptb_pkg::OFF_IRQ_CLEAR) && regs.wdata[ptb_pkg::BIT_EVENT];

  // read mux and address check
  always_comb begin
    regs.rdata = ptb_pkg::READ_ZERO;
    regs.known = 1'b1;
    unique case (regs.addr)
      ptb_pkg::OFF_CONTROL: regs.rdata = {24'h00_0000, controlRead};
      ptb_pkg::OFF_IRQ_STATUS: regs.rdata = {31'h0000_0000, s.flag};
      ptb_pkg::OFF_IRQ_CLEAR: regs.rdata = ptb_pkg::READ_ZERO;
      ptb_pkg::OFF_IRQ_ENABLE: regs.rdata = {31'h0000_0000, s.irqEnable};
      default: regs.known = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    // three stage pin capture
    next_s.extSync = {s.extSync[1:0], externalClock};
    next_s.intSync = {s.intSync[1:0], internalClock};
    if (s.extSync[2] == s.extSync[1]) begin
      next_s.extLevel = s.extSync[2];
    end
    if (s.intSync[2] == s.intSync[1]) begin
      next_s.intLevel = s.intSync[2];
    end
    // control writes, flag bit position ignored
    if (regs.wrEn && (regs.addr == ptb_pkg::OFF_CONTROL)) begin
      next_s.enable = regs.wdata[ptb_pkg::BIT_ENABLE];
      next_s.irqEnable = regs.wdata[ptb_pkg::BIT_IRQ_EN];
      // [RULE12] caller keeps select fixed while running
      next_s.dividerSelect = regs.wdata[ptb_pkg::SEL_LSB +: 3];
    end
    if (regs.wrEn && (regs.addr == ptb_pkg::OFF_IRQ_ENABLE)) begin
      next_s.irqEnable = regs.wdata[ptb_pkg::BIT_EVENT];
    end
    // [RULE4] [RULE9] [RULE10] set beats acknowledge
    next_s.flag = fire || (s.flag && !(ackWrite || clearWrite));
    // [RULE5] [RULE17] level request
    next_s.irq = next_s.flag && next_s.irqEnable;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // [RULE11] enables cleared by reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{ptb_pkg::RST_SYNC, ptb_pkg::RST_SYNC, 1'b0, 1'b0, ptb_pkg::RST_ENABLE,
             ptb_pkg::RST_IRQ_EN, ptb_pkg::RST_SELECT, 1'b0, 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign timebaseIrq = s.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_control_write;
    regs.wrEn && (regs.addr == ptb_pkg::OFF_CONTROL);
  endsequence

  sequence s_ack_no_event;
    ackWrite && !fire;
  endsequence

  property p_ack_clears;
    @(posedge clk) disable iff (!rstn) s_ack_no_event |=> !s.flag ##0 !timebaseIrq;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("acknowledge left flag set"); // [RULE9]

  property p_set_wins;
    @(posedge clk) disable iff (!rstn) (fire && ackWrite) |=> s.flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under acknowledge"); // [RULE4]

  property p_flag_readonly;
    @(posedge clk) disable iff (!rstn)
      (s_control_write and (!regs.wdata[ptb_pkg::BIT_ACK] && !fire && !clearWrite)) |=> $stable(s.flag);
  endproperty
  a_flag_readonly: assert property (p_flag_readonly) else $error("flag changed by a write"); // [RULE10]

  property p_ack_reads_zero;
    @(posedge clk) disable iff (!rstn) pready && !pwrite && (paddr == ptb_pkg::OFF_CONTROL) |-> !prdata[3];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("acknowledge bit read as one"); // [RULE9]

  property p_irq_level;
    @(posedge clk) disable iff (!rstn) (s.flag && s.irqEnable) [*2] |-> timebaseIrq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("request missing while pending"); // [RULE5]

  property p_irq_drop;
    @(posedge clk) disable iff (!rstn) !s.flag |-> !timebaseIrq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("request without pending flag"); // [RULE17]

  property p_fire_sets_flag;
    @(posedge clk) disable iff (!rstn) fire |=> s.flag ##0 (timebaseIrq == s.irqEnable);
  endproperty
  a_fire_sets_flag: assert property (p_fire_sets_flag) else $error("rollover did not set flag"); // [RULE4]

  property p_stop_halts;
    @(posedge clk) disable iff (!rstn) (stopMode && !oscillatorRunInStop) [*2] |-> !fire && $stable(count);
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("timebase ran in stop"); // [RULE15]

  property p_wait_runs;
    @(posedge clk) disable iff (!rstn)
      (waitMode && !stopMode && s.enable && tick) |=> (count == $past(count) + 15'h0001);
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("timebase stalled in wait"); // [RULE13]

  property p_source_select;
    @(posedge clk) disable iff (!rstn)
      (run && externalClockEnable && !extRise) |=> $stable(count);
  endproperty
  a_source_select: assert property (p_source_select) else $error("counted the unselected clock"); // [RULE2]

  property p_disabled_zero;
    @(posedge clk) disable iff (!rstn) !s.enable [*2] |-> (count == 15'h0000);
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("counter not zero while off"); // [RULE3]
endmodule
`default_nettype wire

// File: ptb_clock_model.sv
// source clock model standing in for the clock generator
`timescale 1ns/1ps
`default_nettype none
module ptb_clock_model #(
  parameter int INT_HALF = 3,
  parameter int EXT_HALF = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // generated timebase sources
  output logic internalClock,
  output logic externalClock
);
  logic [7:0] intCount;
  logic [7:0] extCount;
  // each source toggles every half period, slow enough for the capture flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intCount <= 8'h00;
      extCount <= 8'h00;
      internalClock <= 1'b0;
      externalClock <= 1'b0;
    end else begin
      intCount <= (intCount == 8'(INT_HALF - 1)) ? 8'h00 : intCount + 8'h01;
      extCount <= (extCount == 8'(EXT_HALF - 1)) ? 8'h00 : extCount + 8'h01;
      if (intCount == 8'(INT_HALF - 1)) internalClock <= !internalClock;
      if (extCount == 8'(EXT_HALF - 1)) externalClock <= !externalClock;
    end
  end
endmodule
`default_nettype wire

// File: ptb_timebase_test.sv
// self-checking bench for the periodic timebase
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module ptb_timebase_test;
  localparam int INT_P = 6;
  localparam int EXT_P = 8;
  localparam int LIMIT = 95000;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, timebaseIrq;
  logic externalClock, internalClock, externalClockEnable, oscillatorRunInStop, waitMode, stopMode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err;
  int errors = 0;
  int samplesChecked = 0;
  int cyc = 0;
  int divs[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

  // ------------------------------------------------------------
  // instances
  // ------------------------------------------------------------
  ptb_timebase ptb_timebase_i (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .externalClock(externalClock), .internalClock(internalClock), .externalClockEnable(externalClockEnable),
    .oscillatorRunInStop(oscillatorRunInStop), .waitMode(waitMode), .stopMode(stopMode),
    .timebaseIrq(timebaseIrq));
  ptb_clock_model #(.INT_HALF(INT_P / 2), .EXT_HALF(EXT_P / 2)) ptb_clock_model_i (.clk(clk), .rstn(rstn),
    .internalClock(internalClock), .externalClock(externalClock));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // clock and cycle count with hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      finalReport();
    end
  end
  task automatic finalReport();
    $display("checks %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] s, input logic [3:0] low);
    return {25'h000_0000, s, low};
  endfunction
  task automatic waitIrq(output int t);
    for (int k = 0; k < 70000 && timebaseIrq !== 1'b1; k++) @(posedge clk);
    t = cyc;
  endtask
  // acknowledge through the control register, keeping the timebase on
  task automatic ackFlag(input logic [2:0] s);
    apb(1'b1, ptb_pkg::OFF_CONTROL, ctl(s, 4'hE));
    @(posedge clk);
    `CHK(timebaseIrq, 1'b0)
    apb(1'b0, ptb_pkg::OFF_CONTROL, 32'h0000_0000);
    `CHK(rd, ctl(s, 4'h6))
  endtask
  task automatic measure(input logic [2:0] s, input int p, input bit full);
    int n;
    int t0;
    int t1;
    int t2;
    n = divs[s];
    // off before new rate, stale flag acknowledged
    apb(1'b1, ptb_pkg::OFF_CONTROL, 32'h0000_0008);
    apb(1'b1, ptb_pkg::OFF_CONTROL, ctl(s, 4'h6));
    t0 = cyc;
    waitIrq(t1);
    `CHK((t1 - t0 >= (n / 2 - 1) * p) && (t1 - t0 <= n / 2 * p + 10), 1'b1)
    if (full) begin
      ackFlag(s);
      waitIrq(t2);
      `CHK(t2 - t1, n * p)
    end
    ackFlag(s);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic testReset();
    apb(1'b0, ptb_pkg::OFF_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, ptb_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
    apb(1'b1, ptb_pkg::OFF_CONTROL, 32'h0000_0088);
    apb(1'b0, ptb_pkg::OFF_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic testMask();
    apb(1'b1, ptb_pkg::OFF_CONTROL, ctl(3'h7, 4'h2));
    for (int k = 0; k < 40; k++) begin
      apb(1'b0, ptb_pkg::OFF_IRQ_STATUS, 32'h0000_0000);
      if (rd[0] === 1'b1) break;
    end
    `CHK(rd[0], 1'b1)
    `CHK(timebaseIrq, 1'b0)
    apb(1'b1, ptb_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    @(posedge clk);
    `CHK(timebaseIrq, 1'b1)
    apb(1'b1, ptb_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
    @(posedge clk);
    `CHK(timebaseIrq, 1'b0)
  endtask
  task automatic testRates();
    for (int s = 7; s >= 2; s--) measure(3'(s), INT_P, 1'b1);
    measure(3'h1, INT_P, 1'b0);
  endtask
  task automatic testExternal();
    externalClockEnable <= 1'b1;
    measure(3'h7, EXT_P, 1'b1);
    externalClockEnable <= 1'b0;
  endtask
  task automatic testPower();
    waitMode <= 1'b1;
    measure(3'h6, INT_P, 1'b1);
    waitMode <= 1'b0;
    apb(1'b1, ptb_pkg::OFF_CONTROL, 32'h0000_0000);
    apb(1'b1, ptb_pkg::OFF_CONTROL, ctl(3'h7, 4'h6));
    stopMode <= 1'b1;
    repeat (400) @(posedge clk);
    `CHK(timebaseIrq, 1'b0)
    oscillatorRunInStop <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK(timebaseIrq, 1'b1)
    measure(3'h7, INT_P, 1'b1);
    stopMode <= 1'b0;
    apb(1'b1, ptb_pkg::OFF_CONTROL, 32'h0000_0000);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    externalClockEnable = 1'b0;
    oscillatorRunInStop = 1'b0;
    waitMode = 1'b0;
    stopMode = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    testReset();
    testMask();
    testRates();
    testExternal();
    testPower();
    finalReport();
  end
endmodule
`default_nettype wire
